// ### rtl/cpd_pkg.sv
package cpd_pkg;
    // serial slave identity and framing
    localparam logic [6:0] SLAVE_ADDR = 7'h10;
    localparam logic [6:0] GEN_CALL_ADDR = 7'h00;
    localparam int BYTE_BITS = 8;
    localparam int REG_AW = 4;
    localparam int REG_COUNT = 16;
    // system config register index and cell count field
    localparam logic [REG_AW-1:0] SYSTEM_CONFIG_REGISTER_IDX = 4'h0;
    localparam int CELL_LSB = 0;
    localparam int CELL_W = 3;
    localparam logic [7:0] SYSTEM_CONFIG_REGISTER_RST = 8'h04;
    // cells = field + 4, field 0..4 valid
    localparam logic [3:0] CELL_BASE = 4'h4;
    localparam logic [CELL_W-1:0] CELL_MAX_CODE = 3'h4;
    // timing
    localparam int CLK_HZ = 250_000_000;
    localparam int TS_SHORT_S = 8;
    localparam int TS_SHORT_ZD_S = 1;
    localparam longint TS_SHORT_CYC = longint'(TS_SHORT_S) * CLK_HZ;
    localparam longint TS_SHORT_ZD_CYC = longint'(TS_SHORT_ZD_S) * CLK_HZ;
    localparam int TMR_W = 32;
    // grouped byte transfer result
    typedef struct packed {
        logic [REG_AW-1:0] idx;
        logic [7:0] data;
        logic wr;
    } cpd_wr_s;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b011,
        ST_RXB = 3'b010,
        ST_DACK = 3'b110,
        ST_TXB = 3'b111,
        ST_TACK = 3'b101,
        ST_SKIP = 3'b100
    } cpd_state_e;
endpackage : cpd_pkg

// ### rtl/cpd_config_port.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_config_port import cpd_pkg::*; #(
    parameter longint SHORT_CYC = TS_SHORT_CYC,
    parameter longint SHORT_ZD_CYC = TS_SHORT_ZD_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin_in,
    output logic serial_data_pin_out,
    output logic serial_data_pin_oe,
    input wire logic delay_zero_strap,
    input wire logic thermistor_short,
    input wire logic charger_present,
    input wire logic [7:0] prog_delay,
    output logic [7:0] detect_delay,
    output logic [3:0] cell_count,
    output logic shutdown,
    output logic regulator_output_en
);
    // refuse shutdown counts the timer cannot hold
    localparam longint TMR_SPAN = longint'(1) << TMR_W;
    if (SHORT_CYC < 1 || SHORT_ZD_CYC < 1 || SHORT_CYC >= TMR_SPAN
        || SHORT_ZD_CYC >= TMR_SPAN) begin : g_bad_counts
        $error("shutdown counts out of range");
    end
    // location byte must index the whole register map
    if (REG_COUNT != (1 << REG_AW)) begin : g_bad_map
        $error("register map size does not match index width");
    end

    // two-flop synchronisers for the bus, strap, sensor and charger pins
    logic [1:0] scl_s_r, sda_s_r, zd_s_r, ts_s_r, chg_s_r;
    logic scl_d_r, sda_d_r;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            scl_s_r <= 2'h3;
            sda_s_r <= 2'h3;
            zd_s_r <= 2'h0;
            ts_s_r <= 2'h0;
            chg_s_r <= 2'h0;
            scl_d_r <= 1'h1;
            sda_d_r <= 1'h1;
        end else begin
            scl_s_r <= {scl_s_r[0], serial_clk_pin};
            sda_s_r <= {sda_s_r[0], serial_data_pin_in};
            zd_s_r <= {zd_s_r[0], delay_zero_strap};
            ts_s_r <= {ts_s_r[0], thermistor_short};
            chg_s_r <= {chg_s_r[0], charger_present};
            scl_d_r <= scl_s_r[1];
            sda_d_r <= sda_s_r[1];
        end
    end

    // synchronised pin levels
    logic scl, sda, zd, ts_low, chg;
    assign scl = scl_s_r[1];
    assign sda = sda_s_r[1];
    assign zd = zd_s_r[1];
    assign ts_low = ts_s_r[1];
    assign chg = chg_s_r[1];

    // bus events; port live only with strap high and awake
    logic port_en, rise, fall, start_ev, stop_ev;
    assign port_en = zd && !shutdown;
    assign rise = scl && !scl_d_r;
    assign fall = !scl && scl_d_r;
    assign start_ev = scl && scl_d_r && sda_d_r && !sda;
    assign stop_ev = scl && scl_d_r && !sda_d_r && sda;

    cpd_state_e state_r;
    logic [2:0] bit_r;
    logic [7:0] shift_r;
    logic rd_r, idx_done_r, byte_full_r;
    logic [REG_AW-1:0] ptr_r;
    logic [7:0] regs_r [REG_COUNT];
    cpd_wr_s wr_req;
    logic dack_fall, byte_end;

    function automatic logic addr_match(input logic [7:0] b);
        // general call never matches
        addr_match = (b[7:1] == SLAVE_ADDR) && (b[7:1] != GEN_CALL_ADDR);
    endfunction : addr_match

    // cell code to series count, clamped at the top code
    function automatic logic [3:0] cells_of(input logic [CELL_W-1:0] c);
        if (c > CELL_MAX_CODE)
            cells_of = CELL_BASE + 4'(CELL_MAX_CODE);
        else
            cells_of = CELL_BASE + 4'(c);
    endfunction : cells_of

    // clock fall that ends the ack of a received byte
    assign dack_fall = port_en && state_r == ST_DACK && fall;
    // clock fall after the eighth bit of a received byte
    assign byte_end = fall && byte_full_r;

    // eighth rise seen; keeps the fall after start from ending a byte
    always_ff @(posedge clk) begin
        if (!resetn || !port_en || start_ev || stop_ev) begin
            byte_full_r <= 1'b0;
        end else if (rise && bit_r == 3'h7
                     && (state_r == ST_ADDR || state_r == ST_RXB)) begin
            byte_full_r <= 1'b1;
        end else if (fall) begin
            byte_full_r <= 1'b0;
        end
    end

    // first data byte of a write is the location, later ones data
    always_ff @(posedge clk) begin
        if (!resetn || !port_en || start_ev) begin
            idx_done_r <= 1'b0;
        end else if (dack_fall) begin
            idx_done_r <= 1'b1;
        end
    end

    // byte engine on sampled serial clock
    always_ff @(posedge clk) begin
        if (!resetn || !port_en) begin
            state_r <= ST_IDLE;
            bit_r <= 3'h0;
            shift_r <= 8'h00;
            rd_r <= 1'b0;
        end else if (start_ev) begin
            state_r <= ST_ADDR;
            bit_r <= 3'h0;
        end else if (stop_ev) begin
            state_r <= ST_IDLE;
        end else begin
            case (state_r)
                ST_ADDR, ST_RXB: begin
                    if (rise) begin
                        shift_r <= {shift_r[6:0], sda};
                        bit_r <= bit_r + 3'h1;
                    end
                    if (byte_end) begin
                        if (state_r == ST_ADDR) begin
                            if (addr_match(shift_r)) begin
                                rd_r <= shift_r[0];
                                state_r <= ST_AACK;
                            end else begin
                                state_r <= ST_SKIP;
                            end
                        end else begin
                            state_r <= ST_DACK;
                        end
                    end
                end
                ST_AACK, ST_DACK: begin
                    if (fall) begin
                        if (rd_r) begin
                            state_r <= ST_TXB;
                            shift_r <= regs_r[ptr_r];
                        end else begin
                            state_r <= ST_RXB;
                        end
                    end
                end
                ST_TXB: begin
                    if (fall) begin
                        shift_r <= {shift_r[6:0], 1'b0};
                        bit_r <= bit_r + 3'h1;
                        if (bit_r == 3'h7)
                            state_r <= ST_TACK;
                    end
                end
                ST_TACK: begin
                    // master ack: same location again, no increment; nack: skip to stop
                    if (rise)
                        state_r <= sda ? ST_SKIP : ST_TACK;
                    if (fall && !sda_d_r) begin
                        state_r <= ST_TXB;
                        shift_r <= regs_r[ptr_r];
                    end
                end
                ST_SKIP: begin
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end

    // write decode: first data byte sets location, later bytes write it
    always_comb begin
        wr_req = '0;
        wr_req.idx = ptr_r;
        wr_req.data = shift_r;
        wr_req.wr = dack_fall && idx_done_r;
    end

    // location pointer held across transfers, never advanced
    always_ff @(posedge clk) begin
        if (!resetn) begin
            ptr_r <= '0;
        end else if (dack_fall && !idx_done_r) begin
            ptr_r <= shift_r[REG_AW-1:0];
        end
    end

    // register storage; one byte per transfer location
    always_ff @(posedge clk) begin
        if (!resetn) begin
            for (int i = 0; i < REG_COUNT; i++)
                regs_r[i] <= (i == int'(SYSTEM_CONFIG_REGISTER_IDX)) ? SYSTEM_CONFIG_REGISTER_RST : 8'h00;
        end else if (wr_req.wr) begin
            regs_r[wr_req.idx] <= wr_req.data;
        end
    end

    // data pin drive: ack low or transmit bit; clock never driven
    logic drv_nxt;
    always_comb begin
        drv_nxt = 1'b0;
        if (state_r == ST_AACK || (state_r == ST_DACK))
            drv_nxt = 1'b1;
        else if (state_r == ST_TXB && !shift_r[7])
            drv_nxt = 1'b1;
    end
    always_ff @(posedge clk) begin
        if (!resetn) begin
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= 1'b0;
        end else begin
            serial_data_pin_out <= 1'b0;
            serial_data_pin_oe <= port_en && drv_nxt;
        end
    end

    // delay selection and cell count
    logic [CELL_W-1:0] cell_code;
    assign cell_code = regs_r[SYSTEM_CONFIG_REGISTER_IDX][CELL_LSB +: CELL_W];
    always_ff @(posedge clk) begin
        if (!resetn) begin
            detect_delay <= 8'h00;
            cell_count <= CELL_BASE;
        end else begin
            detect_delay <= zd ? 8'h00 : prog_delay;
            cell_count <= cells_of(cell_code);
        end
    end

    // shorted thermistor timer and shutdown latch
    logic [TMR_W-1:0] ts_cnt_r, ts_lim;
    assign ts_lim = zd ? TMR_W'(SHORT_ZD_CYC) : TMR_W'(SHORT_CYC);
    always_ff @(posedge clk) begin
        if (!resetn || !ts_low || shutdown)
            ts_cnt_r <= '0;
        else if (ts_cnt_r != ts_lim)
            ts_cnt_r <= ts_cnt_r + TMR_W'(1);
    end
    // charger wake only clears a latched trip; a trip still latches with the charger present
    logic wake_now, trip_now;
    assign wake_now = shutdown && chg;
    assign trip_now = !shutdown && ts_low && ts_cnt_r == ts_lim;
    always_ff @(posedge clk) begin
        if (!resetn) begin
            shutdown <= 1'b0;
        end else if (wake_now) begin
            shutdown <= 1'b0;
        end else if (trip_now) begin
            shutdown <= 1'b1;
        end
    end

    // regulator output off for as long as the latch holds
    always_ff @(posedge clk) begin
        if (!resetn) begin
            regulator_output_en <= 1'b1;
        end else if (wake_now) begin
            regulator_output_en <= 1'b1;
        end else if (trip_now) begin
            regulator_output_en <= 1'b0;
        end
    end
endmodule : cpd_config_port
`default_nettype wire

// ### test/cpd_config_port_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_config_port_assertions import cpd_pkg::*; #(
    parameter longint SHORT_CYC = TS_SHORT_CYC,
    parameter longint SHORT_ZD_CYC = TS_SHORT_ZD_CYC
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic serial_clk_pin,
    input wire logic serial_data_pin_out,
    input wire logic serial_data_pin_oe,
    input wire logic delay_zero_strap,
    input wire logic thermistor_short,
    input wire logic charger_present,
    input wire logic [7:0] prog_delay,
    input wire logic [7:0] detect_delay,
    input wire logic [3:0] cell_count,
    input wire logic shutdown,
    input wire logic regulator_output_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    longint run_r;
    longint lim;
    // cycles of unbroken shorted sensor
    always_ff @(posedge clk) begin
        if (!resetn || !thermistor_short)
            run_r <= 0;
        else
            run_r <= run_r + 1;
    end
    // limit that applies under the current strap
    always_comb lim = delay_zero_strap ? SHORT_ZD_CYC : SHORT_CYC;
    sequence s_held;
        thermistor_short && !charger_present;
    endsequence
    property p_long; s_held ##0 (!delay_zero_strap && run_r > SHORT_CYC + 8) |-> shutdown; endproperty
    property p_quick; s_held ##0 (delay_zero_strap && run_r > SHORT_ZD_CYC + 8) |-> shutdown; endproperty
    property p_early; $rose(shutdown) |-> run_r + 2 >= lim; endproperty
    property p_stay; shutdown && !charger_present |=> shutdown; endproperty
    property p_ldo; regulator_output_en == !shutdown; endproperty
    property p_port_off; !delay_zero_strap [*4] |-> !serial_data_pin_oe; endproperty
    property p_min_dly; delay_zero_strap [*4] |-> detect_delay == 8'h00; endproperty
    property p_prog_dly; (!delay_zero_strap && $stable(prog_delay)) [*4] |-> detect_delay == prog_delay; endproperty
    property p_open_drain; serial_data_pin_out == 1'b0; endproperty
    property p_oe_low_clk; $changed(serial_data_pin_oe) |-> !serial_clk_pin; endproperty
    property p_cells; cell_count inside {[4'h4:4'h8]}; endproperty
    a_long: assert property (p_long) else $error("no shutdown");
    a_quick: assert property (p_quick) else $error("no shutdown");
    a_early: assert property (p_early) else $error("early shutdown");
    a_stay: assert property (p_stay) else $error("woke early");
    a_ldo: assert property (p_ldo) else $error("ldo state");
    a_port_off: assert property (p_port_off) else $error("port on");
    a_min_dly: assert property (p_min_dly) else $error("delay not min");
    a_prog_dly: assert property (p_prog_dly) else $error("delay wrong");
    a_open_drain: assert property (p_open_drain) else $error("drove high");
    a_oe_low_clk: assert property (p_oe_low_clk) else $error("oe moved");
    a_cells: assert property (p_cells) else $error("cell range");
endmodule : cpd_config_port_assertions
bind cpd_config_port cpd_config_port_assertions #(
    .SHORT_CYC(SHORT_CYC), .SHORT_ZD_CYC(SHORT_ZD_CYC)) u_chk (
    .clk(clk), .resetn(resetn), .serial_clk_pin(serial_clk_pin),
    .serial_data_pin_out(serial_data_pin_out), .prog_delay(prog_delay),
    .serial_data_pin_oe(serial_data_pin_oe), .shutdown(shutdown),
    .delay_zero_strap(delay_zero_strap), .cell_count(cell_count),
    .thermistor_short(thermistor_short), .detect_delay(detect_delay),
    .charger_present(charger_present),
    .regulator_output_en(regulator_output_en));
`default_nettype wire

// ### test/cpd_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module cpd_bus_master (
    input wire logic clk,
    output logic scl,
    output logic sda_low,
    input wire logic sda
);
    // idle bus, both lines released
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // quarter of an 80 ns bus period
    task automatic q;
        repeat (5) @(posedge clk);
        #1;
    endtask : q
    // master alone clocks the bus; data moves while clock is low
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        q();
        scl = 1'b1;
        q();
        s = sda;
        q();
        scl = 1'b0;
        q();
    endtask : bit_io
    task automatic start;
        sda_low = 1'b1;
        q();
        scl = 1'b0;
        q();
    endtask : start
    task automatic stop;
        sda_low = 1'b1;
        q();
        scl = 1'b1;
        q();
        sda_low = 1'b0;
        q();
    endtask : stop
    // msb first; ninth bit released when last, else pulled low
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] r, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
            r[i] = s;
        end
        bit_io(last, s);
        ack = !s;
    endtask : xfer
endmodule : cpd_bus_master
`default_nettype wire

// ### test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb import cpd_pkg::*;;
    localparam longint SC = 200;
    localparam longint ZC = 50;
    logic clk, resetn, scl, m_low, oe, strap, short_in, chg, shdn, ren;
    logic [7:0] prog, dly, r;
    logic [3:0] cells;
    wire logic sda;
    int failures, check_count, cyc;
    // pulled-up open-drain data line
    assign sda = !(m_low || oe);
    cpd_config_port #(.SHORT_CYC(SC), .SHORT_ZD_CYC(ZC)) u_cpd_config_port (
        .clk(clk), .resetn(resetn), .serial_clk_pin(scl),
        .serial_data_pin_in(sda), .serial_data_pin_out(),
        .serial_data_pin_oe(oe), .delay_zero_strap(strap),
        .thermistor_short(short_in), .charger_present(chg),
        .prog_delay(prog), .detect_delay(dly), .cell_count(cells),
        .shutdown(shdn), .regulator_output_en(ren));
    cpd_bus_master u_cpd_bus_master (.clk(clk), .scl(scl), .sda_low(m_low),
        .sda(sda));
    always #2 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : check
    task automatic tally_and_finish;
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : tally_and_finish
    task automatic bt(input logic [7:0] d, input logic ack_exp);
        logic a;
        u_cpd_bus_master.xfer(d, 1'b1, r, a);
        check(a, ack_exp);
    endtask : bt
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk
    // cell codes 0 to 4, then reread without an index
    task automatic t_cells;
        for (int i = 0; i < 5; i++) begin
            u_cpd_bus_master.start();
            bt(8'h20, 1'b1);
            bt(8'h00, 1'b1);
            bt(8'(i), 1'b1);
            u_cpd_bus_master.stop();
            check(cells, 8'(4 + i));
        end
        u_cpd_bus_master.start();
        bt(8'h21, 1'b1);
        bt(8'hff, 1'b0);
        check(r, 8'h04);
        u_cpd_bus_master.stop();
    endtask : t_cells
    // two data bytes land in one register
    task automatic t_burst;
        logic a;
        u_cpd_bus_master.start();
        bt(8'h20, 1'b1);
        bt(8'h03, 1'b1);
        bt(8'ha5, 1'b1);
        bt(8'h5a, 1'b1);
        u_cpd_bus_master.stop();
        u_cpd_bus_master.start();
        bt(8'h21, 1'b1);
        u_cpd_bus_master.xfer(8'hff, 1'b0, r, a);
        check(r, 8'h5a);
        bt(8'hff, 1'b0);
        check(r, 8'h5a);
        u_cpd_bus_master.stop();
    endtask : t_burst
    // foreign addresses, then port with strap low
    task automatic t_refuse;
        u_cpd_bus_master.start();
        bt(8'h00, 1'b0);
        u_cpd_bus_master.stop();
        u_cpd_bus_master.start();
        bt(8'h22, 1'b0);
        u_cpd_bus_master.stop();
        strap = 1'b0;
        wait_clk(8);
        u_cpd_bus_master.start();
        bt(8'h20, 1'b0);
        u_cpd_bus_master.stop();
        check(dly, prog);
        strap = 1'b1;
        wait_clk(8);
        check(dly, 8'h00);
    endtask : t_refuse
    // held short sensor, then charger wake
    task automatic t_short(input logic s, input int lim);
        strap = s;
        wait_clk(8);
        short_in = 1'b1;
        wait_clk(lim - 20);
        check(shdn, 1'b0);
        wait_clk(40);
        check(shdn, 1'b1);
        check(ren, 1'b0);
        short_in = 1'b0;
        wait_clk(20);
        check(shdn, 1'b1);
        chg = 1'b1;
        wait_clk(8);
        chg = 1'b0;
        wait_clk(8);
        check(shdn, 1'b0);
        check(ren, 1'b1);
    endtask : t_short
    // cut a hung run short
    always @(posedge clk) begin
        cyc++;
        if (cyc >= 20000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        clk = 1'b0;
        resetn = 1'b0;
        strap = 1'b1;
        short_in = 1'b0;
        chg = 1'b0;
        prog = 8'h5c;
        wait_clk(8);
        resetn = 1'b1;
        wait_clk(4);
        check(cells, 8'h08);
        t_cells();
        t_burst();
        t_refuse();
        t_short(1'b0, int'(SC));
        t_short(1'b1, int'(ZC));
        tally_and_finish();
    end
endmodule : tb
`default_nettype wire
